// ---- bench/gdp_ext_pins.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Board resistor on the open-drain pin
// ----------------------------------------
module gdp_ext_pins
(
  // Driver view of the pin
  input wire logic i_oe_n,
  input wire logic i_out,
  // Level on the wire
  output logic o_level
);
  // Released pin is pulled high by the resistor
  assign o_level = i_oe_n ? 1'b1 : i_out;
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import gdp_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  gdp_av_req_t req = '0;
  gdp_av_rsp_t rsp;
  gdp_port8_t dat = '0;
  gdp_port8_t po;
  gdp_port8_t oe;
  gdp_port8_t pu;
  logic lvl;
  logic [31:0] rv;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [7:0] DADR [4] = '{8'hb8, 8'hc1, 8'hc2, 8'hc5};
  localparam logic [7:0] PADR [4] = '{8'he0, 8'he1, 8'he2, 8'he5};
  localparam logic [31:0] DEXP [4] = '{32'h01, 32'h0f, 32'h3f, 32'h10};
  always #5 clk = ~clk;
  gdp_port_ctrl dut_u (.i_clk_sys(clk), .i_srst(srst), .i_av(req), .o_av(rsp),
    .i_out_data(dat), .o_pin_out(po), .o_pin_oe_n(oe), .o_pullup_en(pu));
  gdp_ext_pins ext_u (.i_oe_n(oe.p1[0]), .i_out(po.p1[0]), .o_level(lvl));
  // ----------------------------------------
  // Bus access and checking
  // ----------------------------------------
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'h1;
    req.write <= w;
    req.read <= ~w;
    @(posedge clk);
    while (rsp.waitrequest !== 1'b0) @(posedge clk);
    q = rsp.readdata;
    req.write <= 1'b0;
    req.read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
  endtask
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      final_report();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(oe, 32'hffffffff);
    chk(pu, 32'h00020000);
    chk(po, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b0, DADR[i], 32'h0, rv);
      chk(rv, (i == 1) ? 32'h2 : 32'h0);
      acc(1'b1, DADR[i], 32'hff, rv);
      acc(1'b0, DADR[i], 32'h0, rv);
      chk(rv, DEXP[i]);
      acc(1'b1, PADR[i], 32'hff, rv);
      acc(1'b0, PADR[i], 32'h0, rv);
      chk(rv, 32'h0);
    end
    chk(oe, 32'hfef2c0ef);
    chk(pu, 32'h010f3f10);
    for (int i = 0; i < 4; i++)
      acc(1'b1, PADR[i], 32'h0, rv);
    chk(pu, 32'h00020000);
    acc(1'b1, 8'hf0, 32'h80000021, rv);
    acc(1'b0, 8'hc1, 32'h0, rv);
    chk(rv, 32'h0b);
    chk(oe, 32'hfef6c0ef);
    acc(1'b1, 8'hf0, 32'h80000121, rv);
    acc(1'b1, 8'hf0, 32'h80000011, rv);
    acc(1'b0, 8'hc1, 32'h0, rv);
    chk(rv, 32'h0f);
    dat <= '1;
    settle();
    chk({31'h0, po.p1[0]}, 32'h1);
    chk(po, 32'h010d3f10);
    acc(1'b1, 8'he9, 32'h01, rv);
    settle();
    chk({31'h0, oe.p1[0]}, 32'h1);
    chk({31'h0, lvl}, 32'h1);
    dat.p1 <= 8'hfe;
    settle();
    chk({30'h0, oe.p1[0], lvl}, 32'h0);
    acc(1'b0, 8'he9, 32'h0, rv);
    chk(rv, 32'h0);
    dat <= '1;
    acc(1'b1, 8'he9, 32'h00, rv);
    settle();
    chk({30'h0, oe.p1[0], lvl}, 32'h1);
    acc(1'b1, 8'h80, 32'hff, rv);
    acc(1'b0, 8'h80, 32'h0, rv);
    chk(rv, 32'h0);
    acc(1'b0, 8'hb8, 32'h0, rv);
    chk(rv, 32'h01);
    final_report();
  end
endmodule

// ---- hdl/gdp_cfg.svh ----
`ifndef GDP_CFG_SVH
`define GDP_CFG_SVH

// Register offsets (byte addresses)
`define GDP_OFF_P0_DIR 8'hb8
`define GDP_OFF_P1_DIR 8'hc1
`define GDP_OFF_P2_DIR 8'hc2
`define GDP_OFF_P5_DIR 8'hc5
`define GDP_OFF_P0_PU 8'he0
`define GDP_OFF_P1_PU 8'he1
`define GDP_OFF_P2_PU 8'he2
`define GDP_OFF_P5_PU 8'he5
`define GDP_OFF_OD_CTL 8'he9
`define GDP_OFF_BIT_OP 8'hf0
`define GDP_OFF_PIN_OUT 8'hf4

// Implemented bit masks
`define GDP_MASK_P0 8'h01
`define GDP_MASK_P1 8'h0d
`define GDP_MASK_P2 8'h3f
`define GDP_MASK_P5 8'h10
`define GDP_MASK_OD 8'h01

// Fixed-input bit of port 1 and reset value
`define GDP_FIXED_BIT 8'h02
`define GDP_RST_VAL 8'h00

// Bit operation field positions
`define GDP_BOP_SEL_LO 0
`define GDP_BOP_SEL_HI 1
`define GDP_BOP_BIT_LO 4
`define GDP_BOP_BIT_HI 6
`define GDP_BOP_SET 8
`define GDP_BOP_GO 31

// Bus answer on unmapped reads
`define GDP_RD_DEFAULT 32'h0000_0000

`endif

// ---- hdl/gdp_pkg.sv ----
package gdp_pkg;

  typedef struct packed {
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p5;
  } gdp_port8_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } gdp_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } gdp_av_rsp_t;

  typedef enum logic [1:0] {
    GDP_IDLE,
    GDP_DONE
  } gdp_state_t;

endpackage

// ---- hdl/gdp_port_ctrl.sv ----
`timescale 1ns/1ns
`include "gdp_cfg.svh"
// Behaviour
// - Direction bit 0 input, 1 drives output
// - Each implemented pin has own RW direction bit
// - Direction bits support single-bit set and clear
// - P1.1 always input, direction bit reads one
// - Pull-up registers write-only, one enables pull-up
// - P1.1 has no pull-up, bit holds one
// - Open-drain bit selects P1.0 open-drain mode
// - Open-drain drives low, releases for high
// - Open-drain register write-only, whole-byte writes
// - Open-drain off restores prior P1.0 direction
module gdp_port_ctrl
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Avalon-MM slave
  input wire gdp_pkg::gdp_av_req_t i_av,
  output gdp_pkg::gdp_av_rsp_t o_av,
  // Output data from the port data latches
  input wire gdp_pkg::gdp_port8_t i_out_data,
  // Pin drive
  output gdp_pkg::gdp_port8_t o_pin_out,
  output gdp_pkg::gdp_port8_t o_pin_oe_n,
  output gdp_pkg::gdp_port8_t o_pullup_en
);
  import gdp_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  gdp_port8_t dir_q;
  gdp_port8_t pu_q;
  logic od_q;
  gdp_state_t st_q;
  gdp_state_t st_d;
  logic [31:0] rdata_d;
  wire [7:0] od_mask = `GDP_MASK_OD;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req_w = i_av.write && st_q == GDP_IDLE;
  wire req_r = i_av.read && st_q == GDP_IDLE;
  wire lane0 = i_av.byteenable[0];
  wire [7:0] wd = i_av.writedata[7:0];
  wire wr_p0d = req_w && lane0 && i_av.address == `GDP_OFF_P0_DIR;
  wire wr_p1d = req_w && lane0 && i_av.address == `GDP_OFF_P1_DIR;
  wire wr_p2d = req_w && lane0 && i_av.address == `GDP_OFF_P2_DIR;
  wire wr_p5d = req_w && lane0 && i_av.address == `GDP_OFF_P5_DIR;
  wire wr_p0u = req_w && lane0 && i_av.address == `GDP_OFF_P0_PU;
  wire wr_p1u = req_w && lane0 && i_av.address == `GDP_OFF_P1_PU;
  wire wr_p2u = req_w && lane0 && i_av.address == `GDP_OFF_P2_PU;
  wire wr_p5u = req_w && lane0 && i_av.address == `GDP_OFF_P5_PU;
  wire wr_od = req_w && lane0 && i_av.address == `GDP_OFF_OD_CTL;
  wire wr_bop = req_w && i_av.address == `GDP_OFF_BIT_OP
    && i_av.writedata[`GDP_BOP_GO];

  // Single-bit set/clear command
  wire [1:0] bop_sel = i_av.writedata[`GDP_BOP_SEL_HI:`GDP_BOP_SEL_LO];
  wire [2:0] bop_bit = i_av.writedata[`GDP_BOP_BIT_HI:`GDP_BOP_BIT_LO];
  wire bop_val = i_av.writedata[`GDP_BOP_SET];
  wire [7:0] bop_onehot = 8'h01 << bop_bit;
  wire [7:0] bop_p0 = bop_val ? (dir_q.p0 | bop_onehot) : (dir_q.p0 & ~bop_onehot);
  wire [7:0] bop_p1 = bop_val ? (dir_q.p1 | bop_onehot) : (dir_q.p1 & ~bop_onehot);
  wire [7:0] bop_p2 = bop_val ? (dir_q.p2 | bop_onehot) : (dir_q.p2 & ~bop_onehot);
  wire [7:0] bop_p5 = bop_val ? (dir_q.p5 | bop_onehot) : (dir_q.p5 & ~bop_onehot);

  // ----------------------------------------
  // Next values of direction and pull-up
  // ----------------------------------------
  wire [7:0] dir_p0_d = wr_p0d ? wd : (wr_bop && bop_sel == 2'h0) ? bop_p0 : dir_q.p0;
  wire [7:0] dir_p1_d = wr_p1d ? wd : (wr_bop && bop_sel == 2'h1) ? bop_p1 : dir_q.p1;
  wire [7:0] dir_p2_d = wr_p2d ? wd : (wr_bop && bop_sel == 2'h2) ? bop_p2 : dir_q.p2;
  wire [7:0] dir_p5_d = wr_p5d ? wd : (wr_bop && bop_sel == 2'h3) ? bop_p5 : dir_q.p5;
  wire [7:0] pu_p0_d = wr_p0u ? wd : pu_q.p0;
  wire [7:0] pu_p1_d = wr_p1u ? wd : pu_q.p1;
  wire [7:0] pu_p2_d = wr_p2u ? wd : pu_q.p2;
  wire [7:0] pu_p5_d = wr_p5u ? wd : pu_q.p5;
  wire od_d = wr_od ? wd[0] : od_q;

  // Readback: direction registers, plus active-low P1 drive enables at the pin-output offset; pull-up and open-drain read zero
  wire [7:0] rd_p1 = (dir_q.p1 & `GDP_MASK_P1) | `GDP_FIXED_BIT;
  assign rdata_d =
    (i_av.address == `GDP_OFF_P0_DIR) ? {24'h000000, dir_q.p0 & `GDP_MASK_P0} :
    (i_av.address == `GDP_OFF_P1_DIR) ? {24'h000000, rd_p1} :
    (i_av.address == `GDP_OFF_P2_DIR) ? {24'h000000, dir_q.p2 & `GDP_MASK_P2} :
    (i_av.address == `GDP_OFF_P5_DIR) ? {24'h000000, dir_q.p5 & `GDP_MASK_P5} :
    (i_av.address == `GDP_OFF_PIN_OUT) ? {24'h000000, o_pin_oe_n.p1} :
    `GDP_RD_DEFAULT;
  assign st_d = (req_w || req_r) ? GDP_DONE : GDP_IDLE;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      dir_q <= '0;
      pu_q <= '0;
      od_q <= 1'b0;
      st_q <= GDP_IDLE;
    end
    else
    begin
      dir_q <= {dir_p0_d & `GDP_MASK_P0, dir_p1_d & `GDP_MASK_P1,
        dir_p2_d & `GDP_MASK_P2, dir_p5_d & `GDP_MASK_P5};
      pu_q <= {pu_p0_d & `GDP_MASK_P0, pu_p1_d & `GDP_MASK_P1,
        pu_p2_d & `GDP_MASK_P2, pu_p5_d & `GDP_MASK_P5};
      od_q <= od_d & od_mask[0];
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Pin drive, computed from next state so outputs are registered
  // ----------------------------------------
  wire [7:0] nd_p0 = dir_p0_d & `GDP_MASK_P0;
  wire [7:0] nd_p1 = dir_p1_d & `GDP_MASK_P1;
  wire [7:0] nd_p2 = dir_p2_d & `GDP_MASK_P2;
  wire [7:0] nd_p5 = dir_p5_d & `GDP_MASK_P5;
  wire nod = od_d;
  // Open-drain: drive low only, else release; direction bit kept untouched
  wire od_drive = nd_p1[0] && !(nod && i_out_data.p1[0]);
  wire [7:0] oe_p1_n = {~nd_p1[7:1], ~od_drive};
  wire [7:0] out_p1 = {i_out_data.p1[7:1], nod ? 1'b0 : i_out_data.p1[0]};
  wire [7:0] pu_view_p1 = ((wr_p1u ? wd : pu_q.p1) & `GDP_MASK_P1) | `GDP_FIXED_BIT;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_pin_oe_n <= '1;
      o_pin_out <= '0;
      o_pullup_en <= {`GDP_RST_VAL, `GDP_FIXED_BIT, `GDP_RST_VAL, `GDP_RST_VAL};
      o_av <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
    end
    else
    begin
      o_pin_oe_n <= {~nd_p0, oe_p1_n, ~nd_p2, ~nd_p5};
      o_pin_out <= {i_out_data.p0 & nd_p0, out_p1 & {nd_p1[7:1], od_drive},
        i_out_data.p2 & nd_p2, i_out_data.p5 & nd_p5};
      o_pullup_en <= {pu_p0_d & `GDP_MASK_P0, pu_view_p1,
        pu_p2_d & `GDP_MASK_P2, pu_p5_d & `GDP_MASK_P5};
      o_av.waitrequest <= !(req_w || req_r);
      o_av.readdata <= req_r ? rdata_d : o_av.readdata;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_fixed_dir_one: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    req_r && i_av.address == `GDP_OFF_P1_DIR |=> o_av.readdata[1])
    else $error("fixed input direction bit read as zero");
  a_p11_never_drv: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_pin_oe_n.p1[1])
    else $error("fixed input pin driven");
  a_p11_pull_one: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_pullup_en.p1[1])
    else $error("fixed input pullup bit not one");
  a_dir_drive: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wr_p2d |=> o_pin_oe_n.p2 == ~($past(wd) & `GDP_MASK_P2))
    else $error("port 2 drive does not follow direction write");
  a_bit_op_keep: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wr_bop && bop_sel == 2'h2 |=> (dir_q.p2 & ~$past(bop_onehot))
      == ($past(dir_q.p2) & ~$past(bop_onehot)))
    else $error("bit operation disturbed other bits");
  a_pullup_wr: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wr_p0u |=> o_pullup_en.p0[0] == $past(wd[0]))
    else $error("pullup did not follow write");
  a_od_low_rel: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    od_q && !o_pin_oe_n.p1[0] |-> !o_pin_out.p1[0])
    else $error("open-drain pin driven high");
  a_od_restore: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wr_od && !wd[0] ##1 !wr_p1d && !wr_bop |=> o_pin_oe_n.p1[0] == !$past(dir_q.p1[0]))
    else $error("direction not restored after open-drain off");
  a_wait_one: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_av.read || i_av.write) && o_av.waitrequest |=> !o_av.waitrequest)
    else $error("bus answer not in one cycle");
  a_reset_in: assert property (@(posedge i_clk_sys)
    $past(i_srst) |-> o_pin_oe_n == '1 && o_pullup_en == {8'h00, `GDP_FIXED_BIT, 16'h0000})
    else $error("reset did not make all pins inputs");

endmodule
